/* hw/rcd_pkg.sv */
package rcd_pkg;
  // instruction groups, top two bits
  localparam logic [1:0] GRP_BYTE = 2'h0;
  localparam logic [1:0] GRP_BIT  = 2'h1;
  localparam logic [1:0] GRP_JUMP = 2'h2;
  localparam logic [1:0] GRP_LIT  = 2'h3;
  // byte operation codes, bits 11:8
  localparam logic [3:0] OP_MISC  = 4'h0;
  localparam logic [3:0] OP_CLR   = 4'h1;
  localparam logic [3:0] OP_SUB   = 4'h2;
  localparam logic [3:0] OP_DEC   = 4'h3;
  localparam logic [3:0] OP_OR    = 4'h4;
  localparam logic [3:0] OP_AND   = 4'h5;
  localparam logic [3:0] OP_XOR   = 4'h6;
  localparam logic [3:0] OP_ADD   = 4'h7;
  localparam logic [3:0] OP_MOV   = 4'h8;
  localparam logic [3:0] OP_COM   = 4'h9;
  localparam logic [3:0] OP_INC   = 4'hA;
  localparam logic [3:0] OP_DECSZ = 4'hB;
  localparam logic [3:0] OP_RRC   = 4'hC;
  localparam logic [3:0] OP_RLC   = 4'hD;
  localparam logic [3:0] OP_SWAP  = 4'hE;
  localparam logic [3:0] OP_INCSZ = 4'hF;
  // bit operation codes, bits 11:10
  localparam logic [1:0] BOP_CLR   = 2'h0;
  localparam logic [1:0] BOP_SET   = 2'h1;
  localparam logic [1:0] BOP_TSTC  = 2'h2;
  localparam logic [1:0] BOP_TSTS  = 2'h3;
  // control words in the 00 0000 group, low byte
  localparam logic [7:0] CTL_RETURN = 8'h08;
  localparam logic [7:0] CTL_RETINT = 8'h09;
  localparam logic [7:0] CTL_SLEEP  = 8'h63;
  localparam logic [7:0] CTL_WDCLR  = 8'h64;
  // special file addresses
  localparam logic [6:0] ADDR_TIMER  = 7'h01;
  localparam logic [6:0] ADDR_IPLOW  = 7'h02;
  localparam logic [6:0] ADDR_STATUS = 7'h03;
  localparam logic [6:0] ADDR_PORTA  = 7'h05;
  localparam logic [6:0] ADDR_PORTB  = 7'h06;
  localparam logic [6:0] ADDR_LATCH  = 7'h0A;
  // status bit positions
  localparam int ST_C  = 0;
  localparam int ST_DC = 1;
  localparam int ST_Z  = 2;
  localparam int ST_PD = 3;
  localparam int ST_TO = 4;
  // reset values
  localparam logic [7:0]  STATUS_RST = 8'h18;
  localparam logic [12:0] IP_RST     = 13'h0000;
  // timing: oscillator periods in one instruction cycle
  localparam int          PHASES     = 4;
  localparam logic [1:0]  PHASE_LAST = 2'(PHASES - 1);
  localparam int          STACK_DEPTH = 8;
  typedef enum logic [1:0] {PH_Q1, PH_Q2, PH_Q3, PH_Q4} rcd_phase_t;
endpackage : rcd_pkg

/* hw/rcd_stack.sv */
`timescale 1ns/1ps
// return address stack, circular with a registered head
module rcd_stack (
  // clocking
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic        clkEn,
  // control
  input  wire logic        push,
  input  wire logic        pop,
  input  wire logic [12:0] pushAddr,
  // head
  output logic      [12:0] stackHead
);
  logic [12:0] mem [rcd_pkg::STACK_DEPTH];
  logic [2:0]  ptr_q;
  logic [2:0]  ptrNext;
  logic [2:0]  ptrPrev;

  // pointer steps wrap, overflow silently overwrites the oldest entry
  assign ptrNext = ptr_q + 3'h1;
  assign ptrPrev = ptr_q - 3'h1;

  // memory write only on push
  always_ff @(posedge ref_clk) begin
    if (clkEn && push) begin
      mem[ptr_q] <= pushAddr;
    end
  end

  // pointer and registered head
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ptr_q     <= 3'h0;
      stackHead <= 13'h0000;
    end else if (clkEn) begin
      if (push) begin
        ptr_q     <= ptrNext;
        stackHead <= pushAddr;
      end else if (pop) begin
        ptr_q     <= ptrPrev;
        stackHead <= mem[ptrPrev - 3'h1];
      end
    end
  end
endmodule : rcd_stack

/* hw/rcd_core.sv */
`timescale 1ns/1ps
// Summary of operation
// RULE_01: one cycle, two when skipping or jumping
// RULE_02: instruction cycle is four oscillator periods
// RULE_03: top two bits select instruction group
// RULE_04: destination bit picks accumulator or file
// RULE_05: byte fields: opcode, destination, file address
// RULE_06: each operation updates only its own flags
// RULE_07: counting skips store result, skip on zero
// RULE_08: bit words: opcode, bit number, address
// RULE_09: taken bit test discards prefetched word
// RULE_10: literal group decode with don't-care bits
// RULE_11: add literal updates carry, nibble, zero
// RULE_12: subtract literal computes literal minus accumulator
// RULE_13: returns take two cycles, literal loads accumulator
// RULE_14: sleep and watchdog clear decode, one cycle
// RULE_15: don't-care bits never change decoding
// RULE_16: instruction flags override written status bits
// RULE_17: low pointer write copies upper latch high
// RULE_18: bit set and clear rewrite whole byte
// RULE_19: port operands read pin levels
// RULE_20: timer write clears prescaler when assigned
// RULE_21: call and branch load eleven bits plus latch
// RULE_22: watchdog clear zeroes counter, sets both bits
// RULE_23: any pointer write flushes the prefetch
module rcd_core (
  // clocking
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic        clkEn,
  // program memory
  output logic      [12:0] progAddr,
  input  wire logic [13:0] progData,
  // data file space
  output logic      [6:0]  fileAddr,
  input  wire logic [7:0]  fileRdData,
  output logic      [7:0]  fileWrData,
  output logic             fileWrEn,
  // port pins and misc
  input  wire logic [7:0]  portAPins,
  input  wire logic [7:0]  portBPins,
  input  wire logic        prescalerOnTimer,
  input  wire logic        irqReturnSet,
  // side effects
  output logic             prescalerClear,
  output logic             watchdogClear,
  output logic             sleepEnter,
  output logic             globalIrqEnable,
  output logic      [7:0]  accumulator,
  output logic      [7:0]  statusReg,
  output logic      [12:0] instrPointer,
  output logic             cycleEnd
);
  logic [1:0]  phase_q;
  logic [13:0] instr_q;
  logic        flush_q;
  logic [7:0]  acc_q;
  logic [7:0]  status_q;
  logic [12:0] ip_q;
  logic [7:0]  upperLatch_q;
  logic        gie_q;
  logic [12:0] stackHead;

  // instruction cycle built from four oscillator periods
  assign cycleEnd = clkEn && (phase_q == rcd_pkg::PHASE_LAST); // RULE_02
  always_ff @(posedge ref_clk) begin
    if (rst) phase_q <= 2'h0;
    else if (clkEn) phase_q <= phase_q + 2'h1; // RULE_02
  end

  // field extraction
  wire [1:0] grp     = instr_q[13:12]; // RULE_03
  wire [3:0] op      = instr_q[11:8]; // RULE_05
  wire       dBit    = instr_q[7]; // RULE_05
  wire [6:0] fAddr   = instr_q[6:0]; // RULE_05
  wire [1:0] bop     = instr_q[11:10]; // RULE_08
  wire [2:0] bitNum  = instr_q[9:7]; // RULE_08
  wire [7:0] lit     = instr_q[7:0]; // RULE_10
  wire       live    = !flush_q;

  // group and control decode; x bits never inspected
  wire isByte   = live && grp == rcd_pkg::GRP_BYTE; // RULE_03
  wire isBit    = live && grp == rcd_pkg::GRP_BIT; // RULE_03
  wire isJump   = live && grp == rcd_pkg::GRP_JUMP; // RULE_03
  wire isLit    = live && grp == rcd_pkg::GRP_LIT; // RULE_03
  wire isMisc   = isByte && op == rcd_pkg::OP_MISC && !dBit;
  wire isReturn = isMisc && instr_q[6:0] == rcd_pkg::CTL_RETURN[6:0]; // RULE_13
  wire isRetInt = isMisc && instr_q[6:0] == rcd_pkg::CTL_RETINT[6:0]; // RULE_13
  wire isSleep  = isMisc && instr_q[6:0] == rcd_pkg::CTL_SLEEP[6:0]; // RULE_14
  wire isWdClr  = isMisc && instr_q[6:0] == rcd_pkg::CTL_WDCLR[6:0]; // RULE_14
  wire isClrAcc = isByte && op == rcd_pkg::OP_CLR && !dBit; // RULE_15
  wire isRetLit = isLit && instr_q[11:10] == 2'h1; // RULE_10
  wire isLoadLt = isLit && instr_q[11:10] == 2'h0; // RULE_10
  wire isSubLit = isLit && instr_q[11:9] == 3'h6; // RULE_10
  wire isAddLit = isLit && instr_q[11:9] == 3'h7; // RULE_10

  // operand: port registers read the pins, not the latches
  wire [7:0] operand = (fAddr == rcd_pkg::ADDR_PORTA) ? portAPins :
                       (fAddr == rcd_pkg::ADDR_PORTB) ? portBPins :
                       (fAddr == rcd_pkg::ADDR_IPLOW) ? ip_q[7:0] :
                       (fAddr == rcd_pkg::ADDR_STATUS) ? status_q :
                       (fAddr == rcd_pkg::ADDR_LATCH) ? upperLatch_q :
                       fileRdData; // RULE_19 RULE_17

  // adder shared by add and both subtracts; subtraction adds the complement plus one
  wire       doSub   = (isByte && op == rcd_pkg::OP_SUB) || isSubLit;
  wire [7:0] addA    = (isSubLit || isAddLit) ? lit : operand;
  wire [7:0] addB    = doSub ? ~acc_q : acc_q;
  wire       addCin  = doSub;
  wire [4:0] lowSum  = {1'b0, addA[3:0]} + {1'b0, addB[3:0]} + {4'h0, addCin};
  wire [8:0] fullSum = {1'b0, addA} + {1'b0, addB} + {8'h00, addCin}; // RULE_11 RULE_12

  // byte operation result, continuous selection
  logic [7:0] byteRes;
  always_comb begin
    unique case (op)
      rcd_pkg::OP_MISC:  byteRes = acc_q;
      rcd_pkg::OP_CLR:   byteRes = 8'h00;
      rcd_pkg::OP_SUB,
      rcd_pkg::OP_ADD:   byteRes = fullSum[7:0];
      rcd_pkg::OP_DEC,
      rcd_pkg::OP_DECSZ: byteRes = operand - 8'h01;
      rcd_pkg::OP_OR:    byteRes = acc_q | operand;
      rcd_pkg::OP_AND:   byteRes = acc_q & operand;
      rcd_pkg::OP_XOR:   byteRes = acc_q ^ operand;
      rcd_pkg::OP_MOV:   byteRes = operand;
      rcd_pkg::OP_COM:   byteRes = ~operand;
      rcd_pkg::OP_INC,
      rcd_pkg::OP_INCSZ: byteRes = operand + 8'h01;
      rcd_pkg::OP_RRC:   byteRes = {status_q[rcd_pkg::ST_C], operand[7:1]};
      rcd_pkg::OP_RLC:   byteRes = {operand[6:0], status_q[rcd_pkg::ST_C]};
      rcd_pkg::OP_SWAP:  byteRes = {operand[3:0], operand[7:4]};
    endcase
  end

  // literal result
  logic [7:0] litRes;
  always_comb begin
    unique casez (instr_q[11:8])
      4'b00??, 4'b01??: litRes = lit;
      4'b1000:          litRes = acc_q | lit;
      4'b1001:          litRes = acc_q & lit;
      4'b1010:          litRes = acc_q ^ lit;
      4'b110?, 4'b111?: litRes = fullSum[7:0];
      default:          litRes = acc_q; // 1011 unassigned
    endcase
  end

  // bit operation: whole byte rewritten
  wire [7:0] bitMask = 8'h01 << bitNum;
  wire [7:0] bitRes  = (bop == rcd_pkg::BOP_SET) ? (operand | bitMask)
                                                 : (operand & ~bitMask); // RULE_18
  wire       bitVal  = |(operand & bitMask);
  wire       bitWr   = isBit && !bop[1]; // RULE_18

  // flag update classes
  wire isArith   = (isByte && (op == rcd_pkg::OP_ADD || op == rcd_pkg::OP_SUB))
                   || isAddLit || isSubLit; // RULE_06 RULE_11 RULE_12
  wire isRot     = isByte && (op == rcd_pkg::OP_RRC || op == rcd_pkg::OP_RLC); // RULE_06
  wire byteZOps  = op inside {rcd_pkg::OP_CLR, rcd_pkg::OP_DEC, rcd_pkg::OP_OR,
                              rcd_pkg::OP_AND, rcd_pkg::OP_XOR, rcd_pkg::OP_MOV,
                              rcd_pkg::OP_COM, rcd_pkg::OP_INC};
  wire litZOps   = instr_q[11:10] == 2'h2 && instr_q[9:8] != 2'h3;
  wire updZ      = isArith || (isByte && byteZOps && !isMisc) || (isLit && litZOps); // RULE_06
  wire updC      = isArith || isRot; // RULE_06
  wire updDC     = isArith; // RULE_06
  wire [7:0] result = isLit ? litRes : isBit ? bitRes : byteRes;
  wire newC      = isRot ? (op == rcd_pkg::OP_RRC ? operand[0] : operand[7]) : fullSum[8];

  // destination decode
  wire toFile    = (isByte && dBit && !isMisc) || bitWr; // RULE_04 RULE_18
  wire toAcc     = (isByte && !dBit && !isMisc) || isRetLit
                   || (isLit && !isRetLit); // RULE_04 RULE_13
  wire wrStatus  = toFile && fAddr == rcd_pkg::ADDR_STATUS;
  wire wrIpLow   = toFile && fAddr == rcd_pkg::ADDR_IPLOW; // RULE_17
  wire wrLatch   = toFile && fAddr == rcd_pkg::ADDR_LATCH;
  wire wrTimer   = toFile && fAddr == rcd_pkg::ADDR_TIMER;

  // skip and pointer-change decode
  wire cntSkip   = isByte && (op == rcd_pkg::OP_DECSZ || op == rcd_pkg::OP_INCSZ)
                   && byteRes == 8'h00; // RULE_07
  wire bitSkip   = isBit && bop[1] && (bitVal == bop[0]); // RULE_09
  wire jumpTaken = isJump || isReturn || isRetInt || isRetLit; // RULE_21 RULE_13
  wire flushNext = cntSkip || bitSkip || jumpTaken || wrIpLow; // RULE_01 RULE_23

  // status next value: instruction flags override written bits
  logic [7:0] statusD;
  always_comb begin
    statusD = wrStatus ? result : status_q;
    if (updZ) statusD[rcd_pkg::ST_Z] = (result == 8'h00); // RULE_16
    if (updC) statusD[rcd_pkg::ST_C] = newC; // RULE_16
    if (updDC) statusD[rcd_pkg::ST_DC] = lowSum[4]; // RULE_16
    if (isWdClr) begin
      statusD[rcd_pkg::ST_TO] = 1'b1; // RULE_22
      statusD[rcd_pkg::ST_PD] = 1'b1; // RULE_22
    end
    if (isSleep) begin
      statusD[rcd_pkg::ST_TO] = 1'b1; // RULE_14
      statusD[rcd_pkg::ST_PD] = 1'b0; // RULE_14
    end
  end

  // next pointer; a skip takes the plain increment, the prefetched word is discarded by the flush
  wire [12:0] ipInc  = ip_q + 13'h0001;
  wire [12:0] ipJump = {upperLatch_q[4:3], instr_q[10:0]}; // RULE_21
  wire [12:0] ipNext = isJump ? ipJump :
                       (isReturn || isRetInt || isRetLit) ? stackHead :
                       wrIpLow ? {upperLatch_q[4:0], result} : ipInc; // RULE_17

  // program fetch and file port
  assign progAddr   = ip_q;
  assign fileAddr   = fAddr;
  assign fileWrData = result;
  assign fileWrEn   = cycleEnd && toFile;
  assign prescalerClear = cycleEnd && wrTimer && prescalerOnTimer; // RULE_20
  assign watchdogClear  = cycleEnd && isWdClr; // RULE_22
  assign sleepEnter     = cycleEnd && isSleep; // RULE_14
  assign accumulator     = acc_q;
  assign statusReg       = status_q;
  assign instrPointer    = ip_q;
  assign globalIrqEnable = gie_q;

  // return stack, pushes the address after the call
  rcd_stack uStack (
    .ref_clk   (ref_clk),
    .rst       (rst),
    .clkEn     (cycleEnd),
    .push      (isJump && !instr_q[11]), // RULE_21
    .pop       (isReturn || isRetInt || isRetLit),
    .pushAddr  (ip_q),
    .stackHead (stackHead)
  );

  // architectural state commits once per instruction cycle
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      instr_q      <= 14'h0000;
      flush_q      <= 1'b1;
      acc_q        <= 8'h00;
      status_q     <= rcd_pkg::STATUS_RST;
      ip_q         <= rcd_pkg::IP_RST;
      upperLatch_q <= 8'h00;
      gie_q        <= 1'b0;
    end else if (cycleEnd) begin
      instr_q  <= progData;
      flush_q  <= flushNext; // RULE_01 RULE_09 RULE_23
      status_q <= statusD;
      ip_q     <= ipNext;
      if (toAcc || isClrAcc) acc_q <= result; // RULE_04
      if (wrLatch) upperLatch_q <= result;
      if (isRetInt) gie_q <= 1'b1;
      else if (irqReturnSet) gie_q <= 1'b0;
    end
  end

  // a taken skip always leaves a dead slot next cycle
  a_skip_flush: assert property (@(posedge ref_clk) disable iff (rst)
    cycleEnd && flushNext |=> !cycleEnd [*3] ##1 (cycleEnd && flush_q && !fileWrEn))
    else $error("skip or jump did not flush next word"); // RULE_09
  // jump target lands within one instruction cycle
  a_jump_target: assert property (@(posedge ref_clk) disable iff (rst)
    cycleEnd && isJump |=> ##3 ip_q == {$past(upperLatch_q[4:3], 4), $past(instr_q[10:0], 4)})
    else $error("branch target wrong"); // RULE_21
  // helper count of enabled clocks since the last commit; frozen clocks do not count
  logic [2:0] gapCnt_q;
  always_ff @(posedge ref_clk) begin
    if (rst) gapCnt_q <= 3'h0;
    else if (cycleEnd) gapCnt_q <= 3'h0;
    else if (clkEn) gapCnt_q <= gapCnt_q + 3'h1;
  end
  // cycles are exactly four enabled periods apart
  a_cycle_four: assert property (@(posedge ref_clk) disable iff (rst)
    clkEn |-> (cycleEnd == (gapCnt_q == 3'h3)))
    else $error("instruction cycle not four periods"); // RULE_02
  // swap never touches flags
  a_swap_flags: assert property (@(posedge ref_clk) disable iff (rst)
    cycleEnd && isByte && op == rcd_pkg::OP_SWAP && !wrStatus
    |=> status_q[2:0] == $past(status_q[2:0]))
    else $error("swap changed flags"); // RULE_06
  // clearing the status register leaves only zero set among flags
  a_status_over: assert property (@(posedge ref_clk) disable iff (rst)
    cycleEnd && isByte && op == rcd_pkg::OP_CLR && dBit && fAddr == rcd_pkg::ADDR_STATUS
    |=> status_q[2:0] == 3'h4)
    else $error("status override wrong"); // RULE_16
  // subtract literal borrow flag
  a_sub_carry: assert property (@(posedge ref_clk) disable iff (rst)
    cycleEnd && isSubLit |=> status_q[rcd_pkg::ST_C] == ($past(lit) >= $past(acc_q)))
    else $error("subtract literal carry wrong"); // RULE_12
  // prescaler clear follows timer write
  a_timer_pre: assert property (@(posedge ref_clk) disable iff (rst)
    prescalerClear |-> fileWrEn && fileAddr == rcd_pkg::ADDR_TIMER)
    else $error("prescaler clear without timer write"); // RULE_20
  // watchdog clear sets both status bits
  a_wd_bits: assert property (@(posedge ref_clk) disable iff (rst)
    watchdogClear |=> status_q[rcd_pkg::ST_TO] && status_q[rcd_pkg::ST_PD])
    else $error("watchdog clear status wrong"); // RULE_22
  // low pointer write takes the upper latch into the high part
  a_iplow_load: assert property (@(posedge ref_clk) disable iff (rst)
    cycleEnd && wrIpLow |=> ip_q == {$past(upperLatch_q[4:0]), $past(result)})
    else $error("low pointer write target wrong"); // RULE_17
  // counting skips never touch the status bits
  a_cnt_flags: assert property (@(posedge ref_clk) disable iff (rst)
    cycleEnd && isByte && (op == rcd_pkg::OP_DECSZ || op == rcd_pkg::OP_INCSZ) && !wrStatus
    |=> status_q == $past(status_q))
    else $error("counting skip changed status"); // RULE_07
endmodule : rcd_core

/* dv/rcd_mem.sv */
`timescale 1ns/1ps
// program memory and data file space facing the core
module rcd_mem (
  // clocking
  input  wire logic        ref_clk,
  input  wire logic        clkEn,
  // program side
  input  wire logic [12:0] progAddr,
  output logic      [13:0] progData,
  // file side
  input  wire logic [6:0]  fileAddr,
  output logic      [7:0]  fileRdData,
  input  wire logic [7:0]  fileWrData,
  input  wire logic        fileWrEn
);
  logic [13:0] prog [8192];
  logic [7:0]  file [128];

  // reads are combinational, the core samples them on its own edges
  assign progData   = prog[progAddr];
  assign fileRdData = file[fileAddr];

  // writes land only on enabled edges, the same freeze the core obeys
  always @(posedge ref_clk) begin
    if (clkEn && fileWrEn) begin
      file[fileAddr] <= fileWrData;
    end
  end
endmodule : rcd_mem

/* dv/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
  typedef struct packed {
    logic [7:0]  addr;
    logic [13:0] word;
    logic [7:0]  acc;
    logic [2:0]  flg;
    logic [2:0]  pls;
  } rcd_row_t;

  // stimulus
  logic        ref_clk;
  logic        rst         = 1'b1;
  logic        clkEn       = 1'b1;
  logic [7:0]  portAPins   = 8'hA5;
  logic [7:0]  portBPins   = 8'h3C;
  logic        prescalerOnTimer = 1'b1;
  logic        irqReturnSet     = 1'b0;
  // observed
  logic [12:0] progAddr;
  logic [13:0] progData;
  logic [6:0]  fileAddr;
  logic [7:0]  fileRdData;
  logic [7:0]  fileWrData;
  logic        fileWrEn;
  logic        prescalerClear;
  logic        watchdogClear;
  logic        sleepEnter;
  logic        globalIrqEnable;
  logic [7:0]  accumulator;
  logic [7:0]  statusReg;
  logic [12:0] instrPointer;
  logic        cycleEnd;
  int          miscompares = 0;
  int          n_checks    = 0;

  // one row per executed cycle: address, word, accumulator, {z,dc,c}, {presc,wdog,sleep}
  rcd_row_t rows [37] = '{
    '{8'h00, 14'h3010, 8'h10, 3'h0, 3'h0},
    '{8'h01, 14'h3F15, 8'h25, 3'h0, 3'h0},
    '{8'h02, 14'h3C25, 8'h00, 3'h7, 3'h0},
    '{8'h03, 14'h380F, 8'h0F, 3'h3, 3'h0},
    '{8'h04, 14'h0720, 8'h1E, 3'h2, 3'h0},
    '{8'h05, 14'h3A1E, 8'h00, 3'h6, 3'h0},
    '{8'h06, 14'h0FA2, 8'h00, 3'h6, 3'h0},
    '{8'h07, 14'h3077, 8'h00, 3'h6, 3'h0},
    '{8'h08, 14'h3380, 8'h80, 3'h6, 3'h0},
    '{8'h09, 14'h0D23, 8'h02, 3'h7, 3'h0},
    '{8'h0A, 14'h00A4, 8'h02, 3'h7, 3'h0},
    '{8'h0B, 14'h0820, 8'h0F, 3'h3, 3'h0},
    '{8'h0C, 14'h03A1, 8'h0F, 3'h7, 3'h0},
    '{8'h0D, 14'h1821, 8'h0F, 3'h7, 3'h0},
    '{8'h0E, 14'h3055, 8'h0F, 3'h7, 3'h0},
    '{8'h0F, 14'h17A1, 8'h0F, 3'h7, 3'h0},
    '{8'h10, 14'h1F21, 8'h0F, 3'h7, 3'h0},
    '{8'h11, 14'h3033, 8'h33, 3'h7, 3'h0},
    '{8'h12, 14'h0E20, 8'hF0, 3'h7, 3'h0},
    '{8'h13, 14'h0183, 8'hF0, 3'h4, 3'h0},
    '{8'h14, 14'h0225, 8'h20, 3'h2, 3'h0},
    '{8'h15, 14'h0B26, 8'h01, 3'h2, 3'h0},
    '{8'h16, 14'h39FF, 8'h01, 3'h2, 3'h0},
    '{8'h17, 14'h281A, 8'h01, 3'h2, 3'h0},
    '{8'h18, 14'h3099, 8'h01, 3'h2, 3'h0},
    '{8'h1A, 14'h3020, 8'h20, 3'h2, 3'h0},
    '{8'h1B, 14'h0082, 8'h20, 3'h2, 3'h0},
    '{8'h1C, 14'h3099, 8'h20, 3'h2, 3'h0},
    '{8'h20, 14'h3066, 8'h66, 3'h2, 3'h0},
    '{8'h21, 14'h0805, 8'hA5, 3'h2, 3'h0},
    '{8'h22, 14'h0081, 8'hA5, 3'h2, 3'h4},
    '{8'h23, 14'h0064, 8'hA5, 3'h2, 3'h2},
    '{8'h24, 14'h2030, 8'hA5, 3'h2, 3'h0},
    '{8'h25, 14'h0063, 8'hA5, 3'h2, 3'h0},
    '{8'h30, 14'h375A, 8'h5A, 3'h2, 3'h0},
    '{8'h31, 14'h30EE, 8'h5A, 3'h2, 3'h0},
    '{8'h25, 14'h0063, 8'h5A, 3'h2, 3'h1}
  };

  rcd_core dut (
    .ref_clk, .rst, .clkEn, .progAddr, .progData, .fileAddr, .fileRdData,
    .fileWrData, .fileWrEn, .portAPins, .portBPins, .prescalerOnTimer,
    .irqReturnSet, .prescalerClear, .watchdogClear, .sleepEnter,
    .globalIrqEnable, .accumulator, .statusReg, .instrPointer, .cycleEnd
  );

  rcd_mem mem (
    .ref_clk, .clkEn, .progAddr, .progData, .fileAddr, .fileRdData,
    .fileWrData, .fileWrEn
  );

  // free-running oscillator, 8 ns period
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  task automatic check(input logic [15:0] got, input logic [15:0] exp, input string msg);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %0t %s got %h expected %h", $time, msg, got, exp);
    end
  endtask : check

  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : complete_run

  // runs to the next commit edge; pulses are only valid beside cycleEnd
  task automatic stepInstr(output int clks, output logic [2:0] pls);
    clks = 0;
    while (cycleEnd !== 1'b1 && clks < 40) begin
      @(posedge ref_clk);
      #1;
      clks++;
    end
    pls = {prescalerClear, watchdogClear, sleepEnter};
    @(posedge ref_clk);
    #1;
    clks++;
  endtask : stepInstr

  // hang guard, far beyond the few hundred cycles the run needs
  initial begin
    #(8 * 3000);
    miscompares++;
    $display("BAD %0t watchdog expired", $time);
    complete_run();
  end

  initial begin
    int         i;
    int         clks;
    logic [2:0] pls;
    // unused words decode as a visible literal load, so wrong paths show up
    for (i = 0; i < 8192; i++) mem.prog[i] = 14'h30EE;
    for (i = 0; i < 128; i++) mem.file[i] = 8'(i) ^ 8'h5A;
    for (i = 0; i < 37; i++) mem.prog[13'(rows[i].addr)] = rows[i].word;
    mem.file[7'h20] = 8'h0F;
    mem.file[7'h21] = 8'h01;
    mem.file[7'h22] = 8'hFF;
    mem.file[7'h23] = 8'h81;
    mem.file[7'h25] = 8'h10;
    mem.file[7'h26] = 8'h02;
    // tail program for the hand-written cases after the table
    mem.prog[13'h0026] = 14'h0081;
    mem.prog[13'h0027] = 14'h2040;
    mem.prog[13'h0040] = 14'h0009;
    mem.prog[13'h0029] = 14'h0806;
    repeat (10) @(posedge ref_clk);
    #1;
    rst = 1'b0;
    // reset leaves one flushed slot ahead of the word at address zero
    stepInstr(clks, pls);
    check(16'(clks), 16'd4, "reset slot length");
    check(16'(accumulator), 16'h0000, "reset slot idle");
    // table of straight-line, skip, jump and return cases
    for (i = 0; i < 37; i++) begin
      stepInstr(clks, pls);
      check(16'(clks), 16'd4, "cycle length");
      check(16'(accumulator), 16'(rows[i].acc), "accumulator");
      check(16'(statusReg[2:0]), 16'(rows[i].flg), "flags");
      check(16'(pls), 16'(rows[i].pls), "side pulses");
    end
    $display("instruction table done");
    // destinations and read-modify-write results in the file space
    check(16'(mem.file[7'h22]), 16'h0000, "skip counter stored");
    check(16'(mem.file[7'h21]), 16'h0080, "bit set byte");
    check(16'(mem.file[7'h24]), 16'h0002, "accumulator stored");
    check(16'(mem.file[7'h20]), 16'h000F, "file untouched");
    check(16'(mem.file[7'h01]), 16'h00A5, "pin level stored");
    check(16'(statusReg[rcd_pkg::ST_PD]), 16'h0000, "sleep flag");
    $display("file contents done");
    // unassigned prescaler, interrupt return, enable clear, second port
    prescalerOnTimer = 1'b0;
    stepInstr(clks, pls);
    check(16'(pls), 16'h0000, "prescaler kept when unassigned");
    stepInstr(clks, pls);
    check(16'(instrPointer), 16'h0040, "call target");
    stepInstr(clks, pls);
    stepInstr(clks, pls);
    check(16'(globalIrqEnable), 16'h0001, "interrupt return enables");
    check(16'(instrPointer), 16'h0028, "interrupt return target");
    irqReturnSet = 1'b1;
    stepInstr(clks, pls);
    check(16'(globalIrqEnable), 16'h0000, "enable cleared");
    irqReturnSet = 1'b0;
    stepInstr(clks, pls);
    check(16'(accumulator), 16'h00EE, "resumed after return");
    stepInstr(clks, pls);
    check(16'(accumulator), 16'h003C, "second port pins");
    check(16'(mem.file[7'h01]), 16'h005A, "timer write landed");
    $display("awkward cases done");
    // second reset in mid-run
    rst = 1'b1;
    repeat (10) @(posedge ref_clk);
    #1;
    check(16'(accumulator), 16'h0000, "reset accumulator");
    check(16'(statusReg), 16'(rcd_pkg::STATUS_RST), "reset status");
    check(16'(instrPointer), 16'(rcd_pkg::IP_RST), "reset pointer");
    $display("reset test done");
    // held enable must freeze the cycle counter and pointer
    clkEn = 1'b0;
    rst   = 1'b0;
    repeat (20) begin
      @(posedge ref_clk);
      #1;
      check(16'(cycleEnd), 16'h0000, "frozen cycle end");
    end
    check(16'(instrPointer), 16'(rcd_pkg::IP_RST), "frozen pointer");
    clkEn = 1'b1;
    stepInstr(clks, pls);
    check(16'(clks), 16'd4, "first cycle length");
    check(16'(instrPointer), 16'h0001, "first fetch advance");
    check(16'(accumulator), 16'h0000, "flushed first word");
    $display("clock enable test done");
    complete_run();
  end
endmodule : tb_top
